// [tmc_cfg.svh]
// Register map, field positions, reset values and timing constants for the timer block
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH
`define TMC_ADDR_W 2
`define TMC_OFS_CTRL 2'h0
`define TMC_OFS_LOW 2'h1
`define TMC_OFS_HIGH 2'h2
`define TMC_OFS_STAT 2'h3
`define TMC_BIT_RUN 0
`define TMC_BIT_SRC 1
`define TMC_BIT_BYPASS 2
`define TMC_BIT_OSCEN 3
`define TMC_BIT_PS_LO 4
`define TMC_BIT_PS_HI 5
`define TMC_BIT_SYSRUN 6
`define TMC_BIT_WIDE 7
`define TMC_CTRL_RESET 8'h00
`define TMC_CTRL_WMASK 8'hBF
`define TMC_STAT_OVF 0
`define TMC_INSTR_DIV 2'h3
`endif

// [tmc_pkg.sv]
// Types shared by the timer block
package tmc_pkg;
   typedef logic [7:0] tmc_byte_t;
   typedef logic [15:0] tmc_count_t;
endpackage

// [tmc_timer.sv]
// Sixteen-bit timer/counter with prescaler, external/oscillator source and buffered wide access
// How it works
// - Counter advances only while the run bit, control bit 0, is one.
// - Source bit zero: count once per instruction cycle, a quarter of clock.
// - Source bit one: count rising edges of external pin or oscillator output.
// - Prescale field bits 5-4 divides input by 1, 2, 4 or 8.
// - External source: input always synchronised; bit 2 one only selects async mode, which blocks the trigger reset.
// - Internal source ignores the synchronisation bit entirely.
// - Bit 3 enables the crystal oscillator; zero shuts inverter and feedback off.
// - Read-only bit 6 reads one when system clock comes from the oscillator.
// - Bit 7 selects buffered 16-bit access or two independent byte accesses.
// - Wide mode: low byte read copies live high byte into the buffer.
// - Wide mode: high writes fill buffer; low write loads both bytes together.
// - Wide mode: real high byte never accessed directly, only via buffer.
// - Low byte write clears prescaler; high byte write leaves it alone.
// - While the run bit is one the two oscillator pins are inputs and read back zero.
// - Enabled oscillator keeps running through every power-managed mode.
// - Count wraps FFFFh to 0000h, latching overflow flag; enable gates interrupt.
// - Compare trigger resets count to zero, not in async mode, no overflow flag.
// - A counter write in the same cycle as a trigger reset wins.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"
module tmc_timer
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   // Register port
   input wire logic [`TMC_ADDR_W-1:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   // Count sources and system
   input wire logic I_EXT_COUNT_CLOCK,
   input wire logic I_LP_OSC_CLOCK,
   input wire logic I_SYSCLK_FROM_LP_OSC,
   input wire logic I_SPECIAL_TRIGGER,
   input wire logic I_OVERFLOW_IRQ_ENABLE,
   input wire logic I_OVERFLOW_FLAG_CLEAR,
   // Oscillator and pin control, overflow flag and interrupt request
   output logic O_LP_OSC_ENABLE,
   output logic O_PIN_INPUT_FORCE,
   output logic O_OVERFLOW_FLAG,
   output logic O_OVERFLOW_IRQ
);

   ////////////////////////////////////////////////////////////////////
   // Control register and decode
   tmc_byte_t timer_one_control;
   tmc_count_t count;
   tmc_byte_t high_buffer;
   logic [2:0] prescale_count;
   logic overflow_flag;
   logic sysrun_s1, sysrun_s2;
   logic pin_s1, pin_s2, osc_s1, osc_s2, src_prev;

   wire logic count_run_bit = timer_one_control[`TMC_BIT_RUN];
   wire logic source_select_bit = timer_one_control[`TMC_BIT_SRC];
   wire logic sync_bypass_bit = timer_one_control[`TMC_BIT_BYPASS];
   wire logic lp_osc_enable_bit = timer_one_control[`TMC_BIT_OSCEN];
   wire logic [1:0] input_prescale_field = timer_one_control[`TMC_BIT_PS_HI:`TMC_BIT_PS_LO];
   wire logic wide_access_bit = timer_one_control[`TMC_BIT_WIDE];

   wire logic wr_ctrl = I_WR && (I_ADDR == `TMC_OFS_CTRL);
   wire logic wr_low = I_WR && (I_ADDR == `TMC_OFS_LOW);
   wire logic wr_high = I_WR && (I_ADDR == `TMC_OFS_HIGH);
   wire logic rd_low = I_RD && (I_ADDR == `TMC_OFS_LOW);

   // Returns 1 when the prescaler has reached its terminal count for the field code
   function automatic logic prescale_done(input logic [2:0] cnt, input logic [1:0] code);
      logic [2:0] last;
      last = 3'h0;
      case (code)
         2'h0: last = 3'h0;
         2'h1: last = 3'h1;
         2'h2: last = 3'h3;
         default: last = 3'h7;
      endcase
      prescale_done = (cnt == last);
   endfunction

   // Control register, status bit 6 not writable
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         timer_one_control <= `TMC_CTRL_RESET;
      else if (wr_ctrl)
         timer_one_control <= (I_WDATA & `TMC_CTRL_WMASK) | {1'b0, sysrun_s2, 6'h00};
      else
         timer_one_control[`TMC_BIT_SYSRUN] <= sysrun_s2;
   end

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers
   // Pin and oscillator are synchronised apart, so no logic ever reads an unsynchronised level
   // Limitation: switching the oscillator enable while the new source is high looks like one edge
   wire logic src_level = lp_osc_enable_bit ? osc_s2 : pin_s2;
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         sysrun_s1 <= 1'b0;
         sysrun_s2 <= 1'b0;
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         src_prev <= 1'b0;
      end
      else
      begin
         sysrun_s1 <= I_SYSCLK_FROM_LP_OSC;
         sysrun_s2 <= sysrun_s1;
         pin_s1 <= I_EXT_COUNT_CLOCK;
         pin_s2 <= pin_s1;
         osc_s1 <= I_LP_OSC_CLOCK;
         osc_s2 <= osc_s1;
         // Last selected level, for the rising-edge detector
         src_prev <= src_level;
      end
   end

   // Instruction-cycle divider: one tick every four clocks
   logic [1:0] instr_div;
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         instr_div <= 2'h0;
      else
         instr_div <= instr_div + 2'h1;
   end

   // Single clock domain: async mode still counts through the synchronisers, so only the trigger reset differs
   wire logic ext_rise = src_level && !src_prev;
   wire logic src_tick = source_select_bit ? ext_rise : (instr_div == `TMC_INSTR_DIV);
   wire logic async_mode = source_select_bit && sync_bypass_bit;

   ////////////////////////////////////////////////////////////////////
   // Prescaler
   wire logic inc = count_run_bit && src_tick && prescale_done(prescale_count, input_prescale_field);
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         prescale_count <= 3'h0;
      else if (wr_low)
         prescale_count <= 3'h0;
      else if (count_run_bit && src_tick)
         prescale_count <= inc ? 3'h0 : prescale_count + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////
   // Counter with write, trigger reset and increment, write taking priority
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         count <= 16'h0000;
      else if (wr_low)
         count <= {wide_access_bit ? high_buffer : count[15:8], I_WDATA};
      else if (wr_high && !wide_access_bit)
         count[15:8] <= I_WDATA;
      else if (I_SPECIAL_TRIGGER && !async_mode)
         count <= 16'h0000;
      else if (inc)
         count <= count + 16'h0001;
   end

   // High byte buffer
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         high_buffer <= 8'h00;
      else if (wide_access_bit && wr_high)
         high_buffer <= I_WDATA;
      else if (wide_access_bit && rd_low)
         high_buffer <= count[15:8];
   end

   // Overflow flag: set wins over clear
   // A wrap only counts when the increment really lands; a buffer-only write must not hide it
   wire logic count_written = wr_low || (wr_high && !wide_access_bit);
   wire logic trig_clear = I_SPECIAL_TRIGGER && !async_mode;
   wire logic wrap = inc && (count == 16'hFFFF) && !count_written && !trig_clear;
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         overflow_flag <= 1'b0;
      else if (wrap)
         overflow_flag <= 1'b1;
      else if (I_OVERFLOW_FLAG_CLEAR)
         overflow_flag <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Read data and registered outputs
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         O_RDATA <= 8'h00;
      else if (!I_RD)
         O_RDATA <= 8'h00;
      else if (I_ADDR == `TMC_OFS_CTRL)
         O_RDATA <= timer_one_control;
      else if (I_ADDR == `TMC_OFS_LOW)
         O_RDATA <= count[7:0];
      else if (I_ADDR == `TMC_OFS_HIGH)
         O_RDATA <= wide_access_bit ? high_buffer : count[15:8];
      else
         O_RDATA <= {7'h00, overflow_flag};
   end

   // Oscillator enable is only this bit; power modes never gate it
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_LP_OSC_ENABLE <= 1'b0;
         O_PIN_INPUT_FORCE <= 1'b0;
         O_OVERFLOW_FLAG <= 1'b0;
         O_OVERFLOW_IRQ <= 1'b0;
      end
      else
      begin
         O_LP_OSC_ENABLE <= lp_osc_enable_bit;
         O_PIN_INPUT_FORCE <= count_run_bit;
         O_OVERFLOW_FLAG <= overflow_flag;
         O_OVERFLOW_IRQ <= overflow_flag && I_OVERFLOW_IRQ_ENABLE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   chk_stop_holds: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      !count_run_bit && !wr_low && !wr_high && !I_SPECIAL_TRIGGER |=> $stable(count))
      else $error("count moved while stopped");
   chk_wrap_flag: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wrap |=> overflow_flag && count == 16'h0000)
      else $error("wrap did not set flag");
   chk_low_read_buf: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wide_access_bit && rd_low && !I_WR |=> high_buffer == $past(count[15:8]))
      else $error("buffer not loaded on low read");
   chk_wide_write: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wide_access_bit && wr_low |=> count == {$past(high_buffer), $past(I_WDATA)})
      else $error("wide write wrong");
   chk_trig_reset: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      I_SPECIAL_TRIGGER && !async_mode && !I_WR |=> count == 16'h0000 && !$rose(overflow_flag))
      else $error("trigger reset failed");
   chk_write_wins: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wr_low && I_SPECIAL_TRIGGER |=> count[7:0] == $past(I_WDATA))
      else $error("trigger beat write");
   chk_prescale_clr: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wr_low |=> prescale_count == 3'h0)
      else $error("prescaler not cleared");
   chk_internal_rate: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      inc && !source_select_bit |=> !inc [*3])
      else $error("internal tick too fast");
   chk_pin_force: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      count_run_bit |=> O_PIN_INPUT_FORCE)
      else $error("pins not forced");
   // Flag, interrupt and output copies
   chk_flag_sticky: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      overflow_flag && !I_OVERFLOW_FLAG_CLEAR |=> overflow_flag)
      else $error("overflow flag dropped by itself");
   chk_flag_clear: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      I_OVERFLOW_FLAG_CLEAR && !wrap |=> !overflow_flag)
      else $error("overflow flag not cleared");
   chk_irq_gate: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      overflow_flag && I_OVERFLOW_IRQ_ENABLE |=> O_OVERFLOW_IRQ)
      else $error("enabled flag gave no request");
   chk_irq_masked: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      !I_OVERFLOW_IRQ_ENABLE |=> !O_OVERFLOW_IRQ)
      else $error("masked request raised");
   chk_osc_follow: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      1'b1 |=> O_LP_OSC_ENABLE == $past(lp_osc_enable_bit))
      else $error("oscillator enable does not follow bit 3");
   chk_pin_release: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      !count_run_bit |=> !O_PIN_INPUT_FORCE)
      else $error("pins forced while stopped");
   // Register access
   chk_status_ro: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wr_ctrl |=> timer_one_control[`TMC_BIT_SYSRUN] == $past(sysrun_s2))
      else $error("status bit written by software");
   chk_prescale_keep: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wr_high && !(count_run_bit && src_tick) |=> $stable(prescale_count))
      else $error("high write touched prescaler");
   chk_high_via_buf: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      wide_access_bit && wr_high && !I_SPECIAL_TRIGGER && !inc |=> $stable(count))
      else $error("wide high write reached the count");
   chk_byte_high: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      !wide_access_bit && wr_high |=> count[15:8] == $past(I_WDATA))
      else $error("byte high write lost");
   cov_wrap: cover property (@(posedge I_CLK) disable iff (!I_RESET_N) wrap);
   cov_ext_inc: cover property (@(posedge I_CLK) disable iff (!I_RESET_N) inc && source_select_bit);
   cov_wide_write: cover property (@(posedge I_CLK) disable iff (!I_RESET_N) wide_access_bit && wr_low);
   cov_trig: cover property (@(posedge I_CLK) disable iff (!I_RESET_N) I_SPECIAL_TRIGGER && count_run_bit);
   cov_wide_read: cover property (@(posedge I_CLK) disable iff (!I_RESET_N) wide_access_bit && rd_low);

endmodule
`default_nettype wire

// [tmc_src_model.sv]
// Far-side model: external count clock pin and low-power crystal oscillator
`timescale 1ns/1ps
`default_nettype none
module tmc_src_model
(
   // Burst requests from the bench
   input wire logic i_ext_run,
   input wire logic i_osc_run,
   // Clocks towards the timer
   output logic o_ext_clk,
   output logic o_osc_clk
);
   ////////////////////////////////////////////////////////////////
   // Clocks stand low between bursts so every rising edge can be counted
   initial
   begin
      o_ext_clk = 1'b0;
      // Offset keeps pin edges off the timer's sampling edges
      #2;
      forever #35 o_ext_clk = i_ext_run ? ~o_ext_clk : 1'b0;
   end
   // Crystal runs only while asked, slower and unrelated to the pin
   initial
   begin
      o_osc_clk = 1'b0;
      #2;
      forever #45 o_osc_clk = i_osc_run ? ~o_osc_clk : 1'b0;
   end
endmodule
`default_nettype wire

// [tmc_timer_tb.sv]
// Self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"
module tmc_timer_tb;
   ////////////////////////////////////////////////////////////////
   // Stimulus, observed outputs and bookkeeping
   logic I_CLK, I_RESET_N = 1'b0, I_WR = 1'b0, I_RD = 1'b0, I_SYSCLK_FROM_LP_OSC = 1'b0;
   logic I_SPECIAL_TRIGGER = 1'b0, I_OVERFLOW_IRQ_ENABLE = 1'b1, I_OVERFLOW_FLAG_CLEAR = 1'b0;
   logic ext_run = 1'b0, osc_run = 1'b0, ext_clk, osc_clk;
   logic O_LP_OSC_ENABLE, O_PIN_INPUT_FORCE, O_OVERFLOW_FLAG, O_OVERFLOW_IRQ;
   logic [`TMC_ADDR_W-1:0] I_ADDR = 2'h0;
   logic [7:0] I_WDATA = 8'h00, O_RDATA, rdv, m;
   int err_count = 0, num_checks = 0, cyc = 0, n_ext = 0, n_osc = 0, k;
   // Control rows: value written beside value read back
   logic [15:0] rows [4] = '{16'hFFBF, 16'h4808, 16'h8989, 16'h3636};
   logic [7:0] modes [3] = '{8'h03, 8'h07, 8'h0B};

   tmc_timer i_dut
   (
      .I_CLK(I_CLK),
      .I_RESET_N(I_RESET_N),
      .I_ADDR(I_ADDR),
      .I_WDATA(I_WDATA),
      .I_WR(I_WR),
      .I_RD(I_RD),
      .O_RDATA(O_RDATA),
      .I_EXT_COUNT_CLOCK(ext_clk),
      .I_LP_OSC_CLOCK(osc_clk),
      .I_SYSCLK_FROM_LP_OSC(I_SYSCLK_FROM_LP_OSC),
      .I_SPECIAL_TRIGGER(I_SPECIAL_TRIGGER),
      .I_OVERFLOW_IRQ_ENABLE(I_OVERFLOW_IRQ_ENABLE),
      .I_OVERFLOW_FLAG_CLEAR(I_OVERFLOW_FLAG_CLEAR),
      .O_LP_OSC_ENABLE(O_LP_OSC_ENABLE),
      .O_PIN_INPUT_FORCE(O_PIN_INPUT_FORCE),
      .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG),
      .O_OVERFLOW_IRQ(O_OVERFLOW_IRQ)
   );
   tmc_src_model i_src (.i_ext_run(ext_run), .i_osc_run(osc_run), .o_ext_clk(ext_clk), .o_osc_clk(osc_clk));

   ////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial
   begin
      I_CLK = 1'b0;
      forever #5 I_CLK = ~I_CLK;
   end
   // Far-side edge counts give the expected external totals
   always @(posedge ext_clk) n_ext++;
   always @(posedge osc_clk) n_osc++;
   // Run takes about 1600 cycles; the ceiling leaves ample margin
   always @(posedge I_CLK)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         err_count++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1'b1;
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [1:0] a);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_RD <= 1'b1;
      @(posedge I_CLK);
      I_RD <= 1'b0;
      #1;
      rdv = O_RDATA;
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      rd(`TMC_OFS_CTRL);
      check(rdv, 8'h00);
      check({4'h0, O_LP_OSC_ENABLE, O_PIN_INPUT_FORCE, O_OVERFLOW_FLAG, O_OVERFLOW_IRQ}, 8'h00);
      for (k = 0; k < 4; k++)
      begin
         wr(`TMC_OFS_CTRL, rows[k][15:8]);
         rd(`TMC_OFS_CTRL);
         check(rdv, rows[k][7:0]);
         check({6'h0, O_LP_OSC_ENABLE, O_PIN_INPUT_FORCE}, {6'h0, rows[k][11], rows[k][8]});
      end
      I_SYSCLK_FROM_LP_OSC <= 1'b1;
      rd(`TMC_OFS_CTRL);
      rd(`TMC_OFS_CTRL);
      check({7'h0, rdv[`TMC_BIT_SYSRUN]}, 8'h01);
      // 256 cycles per prescale; odd codes also set the ignored sync bit
      for (k = 0; k < 4; k++)
      begin
         wr(`TMC_OFS_CTRL, 8'h00);
         wr(`TMC_OFS_HIGH, 8'h00);
         wr(`TMC_OFS_LOW, 8'h00);
         wr(`TMC_OFS_CTRL, {2'b00, k[1:0], 1'b0, k[0], 2'b01});
         repeat (254) @(posedge I_CLK);
         wr(`TMC_OFS_CTRL, 8'h00);
         rd(`TMC_OFS_LOW);
         m = 8'd64 >> k;
         check({7'h0, rdv + 8'h01 >= m && rdv <= m + 8'h01}, 8'h01);
      end
      repeat (40) @(posedge I_CLK);
      rd(`TMC_OFS_LOW);
      check({7'h0, rdv + 8'h01 >= m && rdv <= m + 8'h01}, 8'h01);
      // External pin synchronised, with bit 2 set (async mode), then crystal
      for (k = 0; k < 3; k++)
      begin
         wr(`TMC_OFS_LOW, 8'h00);
         wr(`TMC_OFS_CTRL, modes[k]);
         repeat (20) @(posedge I_CLK);
         check({7'h0, O_LP_OSC_ENABLE}, {7'h0, modes[k][3]});
         n_ext = 0;
         n_osc = 0;
         ext_run = 1'b1;
         osc_run = modes[k][3];
         #1000;
         ext_run = 1'b0;
         osc_run = 1'b0;
         repeat (10) @(posedge I_CLK);
         wr(`TMC_OFS_CTRL, 8'h00);
         rd(`TMC_OFS_LOW);
         check(rdv, modes[k][3] ? n_osc[7:0] : n_ext[7:0]);
      end
      // Wrap from FFFF raises the flag and the gated request
      wr(`TMC_OFS_HIGH, 8'hFF);
      wr(`TMC_OFS_LOW, 8'hFE);
      wr(`TMC_OFS_CTRL, 8'h01);
      for (k = 0; k < 40 && O_OVERFLOW_FLAG !== 1'b1; k++)
      begin
         @(posedge I_CLK);
         #1;
      end
      check({6'h0, O_OVERFLOW_FLAG, O_OVERFLOW_IRQ}, 8'h03);
      wr(`TMC_OFS_CTRL, 8'h00);
      rd(`TMC_OFS_STAT);
      check({7'h0, rdv[`TMC_STAT_OVF]}, 8'h01);
      rd(`TMC_OFS_HIGH);
      check(rdv, 8'h00);
      // Masking the enable drops the request but keeps the flag
      @(posedge I_CLK);
      I_OVERFLOW_IRQ_ENABLE <= 1'b0;
      @(posedge I_CLK);
      #1;
      check({6'h0, O_OVERFLOW_FLAG, O_OVERFLOW_IRQ}, 8'h02);
      @(posedge I_CLK);
      I_OVERFLOW_FLAG_CLEAR <= 1'b1;
      @(posedge I_CLK);
      I_OVERFLOW_FLAG_CLEAR <= 1'b0;
      rd(`TMC_OFS_STAT);
      check(rdv, 8'h00);
      // Wide mode: reads and writes of the high byte go through the buffer
      wr(`TMC_OFS_HIGH, 8'h12);
      wr(`TMC_OFS_LOW, 8'h34);
      wr(`TMC_OFS_CTRL, 8'h80);
      wr(`TMC_OFS_HIGH, 8'h56);
      rd(`TMC_OFS_HIGH);
      check(rdv, 8'h56);
      rd(`TMC_OFS_LOW);
      check(rdv, 8'h34);
      rd(`TMC_OFS_HIGH);
      check(rdv, 8'h12);
      wr(`TMC_OFS_HIGH, 8'hAB);
      wr(`TMC_OFS_LOW, 8'hCD);
      wr(`TMC_OFS_CTRL, 8'h00);
      rd(`TMC_OFS_HIGH);
      check(rdv, 8'hAB);
      // Trigger clears the count without the flag; a coinciding write wins
      @(posedge I_CLK);
      I_SPECIAL_TRIGGER <= 1'b1;
      @(posedge I_CLK);
      I_SPECIAL_TRIGGER <= 1'b0;
      rd(`TMC_OFS_LOW);
      check(rdv, 8'h00);
      check({7'h0, O_OVERFLOW_FLAG}, 8'h00);
      rd(`TMC_OFS_HIGH);
      check(rdv, 8'h00);
      @(posedge I_CLK);
      I_ADDR <= `TMC_OFS_LOW;
      I_WDATA <= 8'h77;
      I_WR <= 1'b1;
      I_SPECIAL_TRIGGER <= 1'b1;
      @(posedge I_CLK);
      I_WR <= 1'b0;
      I_SPECIAL_TRIGGER <= 1'b0;
      rd(`TMC_OFS_LOW);
      check(rdv, 8'h77);
      // Mid-run reset while running clears control, count and outputs
      wr(`TMC_OFS_CTRL, 8'h8D);
      @(posedge I_CLK);
      I_RESET_N <= 1'b0;
      I_SYSCLK_FROM_LP_OSC <= 1'b0;
      repeat (3) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      rd(`TMC_OFS_CTRL);
      check(rdv, 8'h00);
      rd(`TMC_OFS_LOW);
      check(rdv, 8'h00);
      check({4'h0, O_LP_OSC_ENABLE, O_PIN_INPUT_FORCE, O_OVERFLOW_FLAG, O_OVERFLOW_IRQ}, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
